// ### design/src_cfg.svh
// register offsets, field positions, reset values and frame counts of the readout config bank
`ifndef SRC_CFG_SVH
`define SRC_CFG_SVH

`define SRC_AW               9
`define SRC_DW               16

`define SRC_ADDR_MODE        9'h0c0
`define SRC_ADDR_RSVD_C1     9'h0c1
`define SRC_ADDR_INTEG       9'h0c2
`define SRC_ADDR_WIN_LO      9'h0c3
`define SRC_ADDR_WIN_HI      9'h0c4
`define SRC_ADDR_DARK        9'h0c5
`define SRC_ADDR_SPARE_C6    9'h0c6
`define SRC_ADDR_SCALE       9'h0c7
`define SRC_ADDR_PERIOD      9'h0c8
`define SRC_ADDR_INTEG_TIME  9'h0c9
`define SRC_ADDR_SPARE_CA    9'h0ca
`define SRC_ADDR_SPARE_CB    9'h0cb
`define SRC_ADDR_AMP         9'h0cc

`define SRC_RST_MODE         16'h0000
`define SRC_RST_INTEG        16'h00e4
`define SRC_RST_WIN_LO       16'h0001
`define SRC_RST_WIN_HI       16'h0000
`define SRC_RST_DARK         16'h0102
`define SRC_RST_SCALE        16'h0001
`define SRC_RST_PERIOD       16'h0000
`define SRC_RST_INTEG_TIME   16'h0000
`define SRC_RST_AMP          16'h01e3
`define SRC_RST_DARK_ROWS    8'h02
`define SRC_RST_BLANK        5'h01
`define SRC_RST_MEAN         1'b1

`define SRC_MASK_DARK        16'h1fff

`define SRC_SKIP_EN_BIT      7
`define SRC_MERGE_EN_BIT     8
`define SRC_SKIP_AXIS_LSB    10
`define SRC_MERGE_AXIS_LSB   12
`define SRC_PERIOD_MEAN_BIT  2
`define SRC_DARK_LSB         0
`define SRC_DARK_MSB         7
`define SRC_BLANK_LSB        8
`define SRC_BLANK_MSB        12

`define SRC_HEAD_LAST        5'h09
`define SRC_DATA_LAST        5'h0f
`define SRC_SYNC_RST         3'h2

`endif

// ### design/src_pkg.sv
// types shared by the readout config bank
package src_pkg;
	typedef enum logic [1:0] {
		SRC_AXIS_BOTH   = 2'h0,
		SRC_AXIS_X_ONLY = 2'h1,
		SRC_AXIS_Y_ONLY = 2'h2,
		SRC_AXIS_BOTH3  = 2'h3
	} src_axis_e;

	typedef enum logic [2:0] {
		SRC_SPI_IDLE  = 3'h0,
		SRC_SPI_HEAD  = 3'h1,
		SRC_SPI_WDATA = 3'h2,
		SRC_SPI_RDATA = 3'h3,
		SRC_SPI_DONE  = 3'h4
	} src_spi_st_e;
endpackage

// ### design/src_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/100ps
module src_sync #(
	parameter int          WIDTH   = 3,
	parameter [WIDTH-1:0]  RST_VAL = '0
) (
	input  wire logic             core_clk,
	input  wire logic             rst_b,
	input  wire logic [WIDTH-1:0] din,
	output logic      [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] meta_r;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			meta_r <= RST_VAL;
			dout   <= RST_VAL;
		end else begin
			meta_r <= din;
			dout   <= meta_r;
		end
	end
endmodule

// ### design/src_spi_frame.sv
// serial config port: oversampled frame engine, 9 address bits, write flag, 16 data bits, msb first
`timescale 1ns/100ps
`include "src_cfg.svh"
module src_spi_frame (
	input  wire logic                core_clk,
	input  wire logic                rst_b,
	input  wire logic                spi_sclk,
	input  wire logic                spi_ss_b,
	input  wire logic                spi_mosi,
	input  wire logic [`SRC_DW-1:0]  rd_data,
	output logic                     spi_miso,
	output logic                     spi_miso_oe_b,
	output logic                     wr_stb,
	output logic                     rd_req,
	output logic [`SRC_AW-1:0]       acc_addr,
	output logic [`SRC_DW-1:0]       wr_data
);
	logic [2:0]              pins_s;
	logic                    sclk_s, ss_s, mosi_s;
	logic                    sclk_d_r, rise, fall;
	src_pkg::src_spi_st_e    st_r;
	logic [4:0]              cnt_r;
	logic [`SRC_AW-1:0]      hdr_r;
	logic [`SRC_DW-1:0]      dat_r;
	logic [`SRC_DW-1:0]      sh_r;
	logic                    ld_pend_r;

	src_sync #(.WIDTH(3), .RST_VAL(`SRC_SYNC_RST)) u_sync (
		.core_clk (core_clk),
		.rst_b    (rst_b),
		.din      ({spi_sclk, spi_ss_b, spi_mosi}),
		.dout     (pins_s)
	);

	assign sclk_s = pins_s[2];
	assign ss_s   = pins_s[1];
	assign mosi_s = pins_s[0];
	assign rise   = sclk_s & ~sclk_d_r;
	assign fall   = ~sclk_s & sclk_d_r;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b)
			sclk_d_r <= 1'b0;
		else
			sclk_d_r <= sclk_s;
	end

	// frame sequencing; deselect aborts any frame
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			st_r     <= src_pkg::SRC_SPI_IDLE;
			cnt_r    <= 5'h00;
			hdr_r    <= '0;
			dat_r    <= '0;
			acc_addr <= '0;
			wr_data  <= '0;
			wr_stb   <= 1'b0;
			rd_req   <= 1'b0;
		end else begin
			wr_stb <= 1'b0;
			rd_req <= 1'b0;
			if (ss_s) begin
				st_r  <= src_pkg::SRC_SPI_IDLE;
				cnt_r <= 5'h00;
			end else begin
				case (st_r)
					src_pkg::SRC_SPI_IDLE: begin
						st_r  <= src_pkg::SRC_SPI_HEAD;
						cnt_r <= 5'h00;
					end
					src_pkg::SRC_SPI_HEAD: if (rise) begin
						cnt_r <= cnt_r + 5'h01;
						hdr_r <= {hdr_r[`SRC_AW-2:0], mosi_s};
						if (cnt_r == `SRC_HEAD_LAST) begin
							cnt_r    <= 5'h00;
							acc_addr <= hdr_r;
							rd_req   <= ~mosi_s;
							st_r     <= mosi_s ? src_pkg::SRC_SPI_WDATA : src_pkg::SRC_SPI_RDATA;
						end
					end
					src_pkg::SRC_SPI_WDATA: if (rise) begin
						cnt_r <= cnt_r + 5'h01;
						dat_r <= {dat_r[`SRC_DW-2:0], mosi_s};
						if (cnt_r == `SRC_DATA_LAST) begin
							wr_data <= {dat_r[`SRC_DW-2:0], mosi_s};
							wr_stb  <= 1'b1;
							st_r    <= src_pkg::SRC_SPI_DONE;
						end
					end
					src_pkg::SRC_SPI_RDATA: if (rise) begin
						cnt_r <= cnt_r + 5'h01;
						if (cnt_r == `SRC_DATA_LAST)
							st_r <= src_pkg::SRC_SPI_DONE;
					end
					src_pkg::SRC_SPI_DONE: st_r <= src_pkg::SRC_SPI_DONE;
					default: st_r <= src_pkg::SRC_SPI_IDLE;
				endcase
			end
		end
	end

	// read data: loaded two cycles after the request, shifted out on falling sclk
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			ld_pend_r     <= 1'b0;
			sh_r          <= '0;
			spi_miso      <= 1'b0;
			spi_miso_oe_b <= 1'b1;
		end else begin
			ld_pend_r <= rd_req;
			if (ld_pend_r)
				sh_r <= rd_data;
			else if (fall && st_r == src_pkg::SRC_SPI_RDATA) begin
				spi_miso <= sh_r[`SRC_DW-1];
				sh_r     <= {sh_r[`SRC_DW-2:0], 1'b0};
			end
			spi_miso_oe_b <= ~(~ss_s && st_r == src_pkg::SRC_SPI_RDATA);
		end
	end
endmodule

// ### design/src_regs.sv
// readout configuration register bank behind the serial config port
//
// Overview of operation
// - With skipping on, skip axis code 0 or 3 skips both axes, 1 only horizontal, 2 only vertical.
// - With merging on, merge axis code 0 or 3 merges both axes, 1 only horizontal, 2 only vertical.
// - Low window mask bit n enables readout window n, and only window 0 is on after reset.
// - High window mask bit n enables readout window 16+n, and all of them are off after reset.
// - An 8-bit field gives the dark reference row count, legal 1 to 255, reset 2.
// - A 5-bit field blanks that many leading rows, 0 blanking none, reset 1.
// - A 16-bit scale sets the timing unit in clock periods for integration and reset length, reset 1.
// - The period register, in timing units, is the reset length when the meaning bit is 0, else the frame length.
// - The period meaning bit selects reset length (0) or frame length (1) and resets to 1.
// - The skip enable bit turns skipping on, and the skip axis field acts only while it is set.
// - The merge enable bit turns merging on, and the merge axis field acts only while it is set.
`timescale 1ns/100ps
`include "src_cfg.svh"
module src_regs (
	input  wire logic        core_clk,
	input  wire logic        rst_b,
	input  wire logic        spi_sclk,
	input  wire logic        spi_ss_b,
	input  wire logic        spi_mosi,
	output logic             spi_miso,
	output logic             spi_miso_oe_b,
	output logic             skip_x_en,
	output logic             skip_y_en,
	output logic             merge_x_en,
	output logic             merge_y_en,
	output logic [31:0]      window_enable,
	output logic [7:0]       dark_row_count,
	output logic [4:0]       leading_blank_rows,
	output logic [15:0]      timing_unit_scale,
	output logic             period_length_meaning,
	output logic [15:0]      reset_length,
	output logic [15:0]      frame_length,
	output logic [15:0]      integration_time,
	output logic [15:0]      analog_amp_setup,
	output logic             unit_tick
);
	logic                    wr_stb;
	logic                    rd_req;
	logic [`SRC_AW-1:0]      acc_addr;
	logic [`SRC_DW-1:0]      wr_data;
	logic [`SRC_DW-1:0]      rd_data_r;
	logic [15:0]             mode_r;
	logic [15:0]             integ_r;
	logic [15:0]             window_enable_low;
	logic [15:0]             window_enable_high;
	logic [15:0]             dark_row_config;
	logic [15:0]             timing_unit_scale_r;
	logic [15:0]             period_length_setting;
	logic [15:0]             integration_time_setting;
	logic [15:0]             analog_amp_setup_r;
	logic [15:0]             unit_cnt_r;
	logic [15:0]             unit_last;
	src_pkg::src_axis_e      skip_axis, merge_axis;

	function automatic logic axis_has_x(input src_pkg::src_axis_e code);
		return code != src_pkg::SRC_AXIS_Y_ONLY;
	endfunction

	function automatic logic axis_has_y(input src_pkg::src_axis_e code);
		return code != src_pkg::SRC_AXIS_X_ONLY;
	endfunction

	src_spi_frame u_frame (
		.core_clk      (core_clk),
		.rst_b         (rst_b),
		.spi_sclk      (spi_sclk),
		.spi_ss_b      (spi_ss_b),
		.spi_mosi      (spi_mosi),
		.rd_data       (rd_data_r),
		.spi_miso      (spi_miso),
		.spi_miso_oe_b (spi_miso_oe_b),
		.wr_stb        (wr_stb),
		.rd_req        (rd_req),
		.acc_addr      (acc_addr),
		.wr_data       (wr_data)
	);

	// register writes; reserved addresses ignore writes
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			mode_r                   <= `SRC_RST_MODE;
			integ_r                  <= `SRC_RST_INTEG;
			window_enable_low        <= `SRC_RST_WIN_LO;
			window_enable_high       <= `SRC_RST_WIN_HI;
			dark_row_config          <= `SRC_RST_DARK;
			timing_unit_scale_r      <= `SRC_RST_SCALE;
			period_length_setting    <= `SRC_RST_PERIOD;
			integration_time_setting <= `SRC_RST_INTEG_TIME;
			analog_amp_setup_r       <= `SRC_RST_AMP;
		end else if (wr_stb) begin
			case (acc_addr)
				`SRC_ADDR_MODE:       mode_r <= wr_data;
				`SRC_ADDR_INTEG:      integ_r <= wr_data;
				`SRC_ADDR_WIN_LO:     window_enable_low <= wr_data;
				`SRC_ADDR_WIN_HI:     window_enable_high <= wr_data;
				`SRC_ADDR_DARK:       dark_row_config <= wr_data & `SRC_MASK_DARK;
				`SRC_ADDR_SCALE:      timing_unit_scale_r <= wr_data;
				`SRC_ADDR_PERIOD:     period_length_setting <= wr_data;
				`SRC_ADDR_INTEG_TIME: integration_time_setting <= wr_data;
				`SRC_ADDR_AMP:        analog_amp_setup_r <= wr_data;
				default:              mode_r <= mode_r;
			endcase
		end
	end

	// read mux; reserved and unmapped addresses read zero
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b)
			rd_data_r <= '0;
		else if (rd_req) begin
			case (acc_addr)
				`SRC_ADDR_MODE:       rd_data_r <= mode_r;
				`SRC_ADDR_INTEG:      rd_data_r <= integ_r;
				`SRC_ADDR_WIN_LO:     rd_data_r <= window_enable_low;
				`SRC_ADDR_WIN_HI:     rd_data_r <= window_enable_high;
				`SRC_ADDR_DARK:       rd_data_r <= dark_row_config;
				`SRC_ADDR_SCALE:      rd_data_r <= timing_unit_scale_r;
				`SRC_ADDR_PERIOD:     rd_data_r <= period_length_setting;
				`SRC_ADDR_INTEG_TIME: rd_data_r <= integration_time_setting;
				`SRC_ADDR_AMP:        rd_data_r <= analog_amp_setup_r;
				default:              rd_data_r <= '0;
			endcase
		end
	end

	assign skip_axis  = src_pkg::src_axis_e'(mode_r[`SRC_SKIP_AXIS_LSB +: 2]);
	assign merge_axis = src_pkg::src_axis_e'(mode_r[`SRC_MERGE_AXIS_LSB +: 2]);

	// decoded skip and merge axes
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			skip_x_en  <= 1'b0;
			skip_y_en  <= 1'b0;
			merge_x_en <= 1'b0;
			merge_y_en <= 1'b0;
		end else begin
			skip_x_en  <= mode_r[`SRC_SKIP_EN_BIT] & axis_has_x(skip_axis);
			skip_y_en  <= mode_r[`SRC_SKIP_EN_BIT] & axis_has_y(skip_axis);
			merge_x_en <= mode_r[`SRC_MERGE_EN_BIT] & axis_has_x(merge_axis);
			merge_y_en <= mode_r[`SRC_MERGE_EN_BIT] & axis_has_y(merge_axis);
		end
	end

	// windows, row counts and timing settings
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			window_enable         <= {`SRC_RST_WIN_HI, `SRC_RST_WIN_LO};
			dark_row_count        <= `SRC_RST_DARK_ROWS;
			leading_blank_rows    <= `SRC_RST_BLANK;
			timing_unit_scale     <= `SRC_RST_SCALE;
			period_length_meaning <= `SRC_RST_MEAN;
			reset_length          <= 16'h0000;
			frame_length          <= `SRC_RST_PERIOD;
			integration_time      <= `SRC_RST_INTEG_TIME;
			analog_amp_setup      <= `SRC_RST_AMP;
		end else begin
			window_enable         <= {window_enable_high, window_enable_low};
			dark_row_count        <= dark_row_config[`SRC_DARK_MSB:`SRC_DARK_LSB];
			leading_blank_rows    <= dark_row_config[`SRC_BLANK_MSB:`SRC_BLANK_LSB];
			timing_unit_scale     <= timing_unit_scale_r;
			period_length_meaning <= integ_r[`SRC_PERIOD_MEAN_BIT];
			reset_length          <= integ_r[`SRC_PERIOD_MEAN_BIT] ? 16'h0000 : period_length_setting;
			frame_length          <= integ_r[`SRC_PERIOD_MEAN_BIT] ? period_length_setting : 16'h0000;
			integration_time      <= integration_time_setting;
			analog_amp_setup      <= analog_amp_setup_r;
		end
	end

	// timing unit: one tick every scale clocks, a scale of zero acts as one
	assign unit_last = (timing_unit_scale_r == 16'h0000) ? 16'h0000 : timing_unit_scale_r - 16'h0001;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			unit_cnt_r <= 16'h0000;
			unit_tick  <= 1'b0;
		end else if (unit_cnt_r >= unit_last) begin
			unit_cnt_r <= 16'h0000;
			unit_tick  <= 1'b1;
		end else begin
			unit_cnt_r <= unit_cnt_r + 16'h0001;
			unit_tick  <= 1'b0;
		end
	end

	// helper state for the checks below
	logic        first_r;
	logic [16:0] gap_r;
	logic        scale_moved_r;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			first_r       <= 1'b1;
			gap_r         <= 17'h00000;
			scale_moved_r <= 1'b1;
		end else begin
			first_r <= 1'b0;
			gap_r   <= unit_tick ? 17'h00001 : gap_r + 17'h00001;
			if (wr_stb && acc_addr == `SRC_ADDR_SCALE)
				scale_moved_r <= 1'b1;
			else if (unit_tick)
				scale_moved_r <= 1'b0;
		end
	end

	sequence s_write_to(logic [`SRC_AW-1:0] a);
		wr_stb && acc_addr == a;
	endsequence

	sequence s_settle;
		##2 1'b1;
	endsequence

	a_skip_axis_x: assert property (@(posedge core_clk) disable iff (!rst_b)
		skip_x_en == $past(mode_r[7] && mode_r[11:10] != 2'h2))
		else $error("skip horizontal decode wrong");

	a_skip_axis_y: assert property (@(posedge core_clk) disable iff (!rst_b)
		skip_y_en == $past(mode_r[7] && mode_r[11:10] != 2'h1))
		else $error("skip vertical decode wrong");

	a_merge_axis_both: assert property (@(posedge core_clk) disable iff (!rst_b)
		(mode_r[8] && mode_r[13:12] == 2'h3) |=> (merge_x_en && merge_y_en))
		else $error("merge code three not both axes");

	a_merge_axis_single: assert property (@(posedge core_clk) disable iff (!rst_b)
		(mode_r[8] && mode_r[13:12] == 2'h1) |=> (merge_x_en && !merge_y_en))
		else $error("merge code one not horizontal only");

	a_win_low_write: assert property (@(posedge core_clk) disable iff (!rst_b)
		s_write_to(9'h0c3) ##0 s_settle |-> window_enable[15:0] == $past(wr_data, 2))
		else $error("low window mask not applied");

	a_win_high_write: assert property (@(posedge core_clk) disable iff (!rst_b)
		s_write_to(9'h0c4) ##0 s_settle |-> window_enable[31:16] == $past(wr_data, 2))
		else $error("high window mask not applied");

	a_reset_values: assert property (@(posedge core_clk) disable iff (!rst_b)
		first_r |-> (window_enable == 32'h00000001 && dark_row_count == 8'h02 && leading_blank_rows == 5'h01
			&& timing_unit_scale == 16'h0001 && period_length_meaning))
		else $error("reset values wrong");

	a_dark_rows_field: assert property (@(posedge core_clk) disable iff (!rst_b)
		s_write_to(9'h0c5) |=> ##1 (dark_row_count == $past(wr_data[7:0], 2)
			&& leading_blank_rows == $past(wr_data[12:8], 2)))
		else $error("dark row or blank fields wrong");

	a_unit_spacing: assert property (@(posedge core_clk) disable iff (!rst_b)
		(unit_tick && !scale_moved_r && timing_unit_scale_r != 16'h0000)
			|-> gap_r == {1'b0, timing_unit_scale_r})
		else $error("timing unit length wrong");

	a_period_meaning: assert property (@(posedge core_clk) disable iff (!rst_b)
		$past(integ_r[2]) |-> (frame_length == $past(period_length_setting) && reset_length == 16'h0000))
		else $error("period read as wrong length");

	a_period_reset_len: assert property (@(posedge core_clk) disable iff (!rst_b)
		!$past(integ_r[2]) |-> (reset_length == $past(period_length_setting) && !period_length_meaning))
		else $error("period not read as reset length");

	a_skip_gate: assert property (@(posedge core_clk) disable iff (!rst_b)
		!mode_r[7] [*2] |-> !skip_x_en && !skip_y_en)
		else $error("skip active while disabled");

	a_merge_gate: assert property (@(posedge core_clk) disable iff (!rst_b)
		!mode_r[8] [*2] |-> !merge_x_en && !merge_y_en)
		else $error("merge active while disabled");

	sequence s_read_of(logic [`SRC_AW-1:0] a);
		rd_req && acc_addr == a;
	endsequence

	a_merge_axis_x: assert property (@(posedge core_clk) disable iff (!rst_b)
		merge_x_en == $past(mode_r[8] && mode_r[13:12] != 2'h2))
		else $error("merge horizontal decode wrong");

	a_merge_axis_y: assert property (@(posedge core_clk) disable iff (!rst_b)
		merge_y_en == $past(mode_r[8] && mode_r[13:12] != 2'h1))
		else $error("merge vertical decode wrong");

	a_scale_follow: assert property (@(posedge core_clk) disable iff (!rst_b)
		timing_unit_scale == $past(timing_unit_scale_r))
		else $error("timing unit scale output stale");

	a_tick_unit_one: assert property (@(posedge core_clk) disable iff (!rst_b)
		(!first_r && $past(timing_unit_scale_r) <= 16'h0001) |-> unit_tick)
		else $error("no tick every clock at unit one");

	a_meaning_follow: assert property (@(posedge core_clk) disable iff (!rst_b)
		period_length_meaning == $past(integ_r[`SRC_PERIOD_MEAN_BIT]))
		else $error("period meaning output stale");

	a_window_follow: assert property (@(posedge core_clk) disable iff (!rst_b)
		window_enable == $past({window_enable_high, window_enable_low}))
		else $error("window enables not following masks");

	a_dark_follow: assert property (@(posedge core_clk) disable iff (!rst_b)
		dark_row_count == $past(dark_row_config[7:0]))
		else $error("dark row count output stale");

	a_blank_follow: assert property (@(posedge core_clk) disable iff (!rst_b)
		leading_blank_rows == $past(dark_row_config[12:8]))
		else $error("leading blank rows output stale");

	a_spare_read_zero: assert property (@(posedge core_clk) disable iff (!rst_b)
		s_read_of(`SRC_ADDR_SPARE_C6) |=> rd_data_r == 16'h0000)
		else $error("spare register read not zero");
endmodule

// ### tb/src_regs_bench.sv
// self-checking bench for the readout config register bank, driven over its serial port
`timescale 1ns/100ps
module src_regs_bench;
	logic         core_clk;
	logic         rst_b;
	logic         spi_sclk;
	logic         spi_ss_b;
	logic         spi_mosi;
	logic         spi_miso;
	logic         spi_miso_oe_b;
	logic         skip_x_en;
	logic         skip_y_en;
	logic         merge_x_en;
	logic         merge_y_en;
	logic [31:0]  window_enable;
	logic [7:0]   dark_row_count;
	logic [4:0]   leading_blank_rows;
	logic [15:0]  timing_unit_scale;
	logic         period_length_meaning;
	logic [15:0]  reset_length;
	logic [15:0]  frame_length;
	logic [15:0]  integration_time;
	logic [15:0]  analog_amp_setup;
	logic         unit_tick;
	logic [129:0] obs_all;
	logic [15:0]  mirror [0:12];
	logic [15:0]  wexp_q [$];
	logic [15:0]  wgot_q [$];
	logic [129:0] oexp_q [$];
	logic [129:0] ogot_q [$];
	logic         oe_mid;
	logic [15:0]  rd;
	int           mismatches;
	int           total_checks;
	int           k;
	int unsigned  seed_val;

	src_regs DUT (
		.core_clk              (core_clk),
		.rst_b                 (rst_b),
		.spi_sclk              (spi_sclk),
		.spi_ss_b              (spi_ss_b),
		.spi_mosi              (spi_mosi),
		.spi_miso              (spi_miso),
		.spi_miso_oe_b         (spi_miso_oe_b),
		.skip_x_en             (skip_x_en),
		.skip_y_en             (skip_y_en),
		.merge_x_en            (merge_x_en),
		.merge_y_en            (merge_y_en),
		.window_enable         (window_enable),
		.dark_row_count        (dark_row_count),
		.leading_blank_rows    (leading_blank_rows),
		.timing_unit_scale     (timing_unit_scale),
		.period_length_meaning (period_length_meaning),
		.reset_length          (reset_length),
		.frame_length          (frame_length),
		.integration_time      (integration_time),
		.analog_amp_setup      (analog_amp_setup),
		.unit_tick             (unit_tick)
	);

	assign obs_all = {skip_x_en, skip_y_en, merge_x_en, merge_y_en, period_length_meaning, window_enable,
		dark_row_count, leading_blank_rows, timing_unit_scale, reset_length, frame_length, integration_time,
		analog_amp_setup};

	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end

	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask

	task automatic reset_mirror();
		for (int i = 0; i < 13; i++) mirror[i] = 16'h0000;
		mirror[2] = 16'h00e4;
		mirror[3] = 16'h0001;
		mirror[5] = 16'h0102;
		mirror[7] = 16'h0001;
		mirror[12] = 16'h01e3;
	endtask

	function automatic logic writable(input logic [8:0] a);
		return a >= 9'h0c0 && a <= 9'h0cc && a != 9'h0c1 && a != 9'h0c6 && a != 9'h0ca && a != 9'h0cb;
	endfunction

	// decoded outputs as the rules derive them from the register contents
	function automatic logic [129:0] exp_out();
		logic [15:0] m;
		logic        mean;
		m = mirror[0];
		mean = mirror[2][2];
		return {m[7] && m[11:10] != 2'h2, m[7] && m[11:10] != 2'h1, m[8] && m[13:12] != 2'h2,
			m[8] && m[13:12] != 2'h1, mean, mirror[4], mirror[3], mirror[5][7:0], mirror[5][12:8], mirror[7],
			mean ? 16'h0000 : mirror[8], mean ? mirror[8] : 16'h0000, mirror[9], mirror[12]};
	endfunction

	task automatic note_word(input logic [15:0] e, input logic [15:0] g);
		wexp_q.push_back(e);
		wgot_q.push_back(g);
	endtask

	task automatic note_out(input logic [129:0] e);
		oexp_q.push_back(e);
		ogot_q.push_back(obs_all);
	endtask

	task automatic cmp_word(input logic [15:0] e, input logic [15:0] g);
		total_checks++;
		if (g !== e) begin
			mismatches++;
			$display("CHECK FAILED t=%0t word expected %h got %h", $time, e, g);
		end
	endtask

	task automatic cmp_out(input logic [129:0] e, input logic [129:0] g);
		total_checks++;
		if (g !== e) begin
			mismatches++;
			$display("CHECK FAILED t=%0t outputs expected %h got %h", $time, e, g);
		end
	endtask

	// watcher: takes the oldest note whenever a result has been posted
	initial begin
		forever begin
			@(negedge core_clk);
			while (wgot_q.size() > 0) cmp_word(wexp_q.pop_front(), wgot_q.pop_front());
			while (ogot_q.size() > 0) cmp_out(oexp_q.pop_front(), ogot_q.pop_front());
		end
	end

	// frame: 9 address bits, write flag, 16 data bits, msb first; fewer bits aborts the frame
	task automatic spi_xfer(input logic [8:0] a, input logic w, input logic [15:0] d, input int nbits,
		output logic [15:0] q);
		logic [25:0] bits;
		bits = {a, w, d};
		q = 16'h0000;
		spi_ss_b = 1'b0;
		cyc(6);
		for (int i = 0; i < nbits; i++) begin
			spi_mosi = bits[25-i];
			cyc(10);
			if (i >= 10) q[25-i] = spi_miso;
			if (i == 15) oe_mid = spi_miso_oe_b;
			spi_sclk = 1'b1;
			cyc(10);
			spi_sclk = 1'b0;
		end
		spi_mosi = ~spi_mosi;
		cyc(10);
		spi_ss_b = 1'b1;
		cyc(8);
	endtask

	task automatic wr(input logic [8:0] a, input logic [15:0] d);
		logic [15:0] q;
		spi_xfer(a, 1'b1, d, 26, q);
		if (writable(a)) mirror[a - 9'h0c0] = (a == 9'h0c5) ? (d & 16'h1fff) : d;
		note_out(exp_out());
	endtask

	task automatic rd_chk(input logic [8:0] a);
		logic [15:0] q;
		spi_xfer(a, 1'b0, 16'(seed_val), 26, q);
		note_word(writable(a) ? mirror[a - 9'h0c0] : 16'h0000, q);
		note_word(16'h0000, {15'h0000, oe_mid});
		note_word(16'h0001, {15'h0000, spi_miso_oe_b});
	endtask

	task automatic tick_cnt(input int n, input logic [15:0] e);
		int c;
		c = 0;
		repeat (n) begin
			cyc(1);
			c += int'(unit_tick);
		end
		note_word(e, 16'(c));
	endtask

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	initial begin
		repeat (100000) @(posedge core_clk);
		mismatches++;
		$display("CHECK FAILED t=%0t run limit reached", $time);
		print_verdict();
	end

	initial begin
		spi_sclk = 1'b0;
		spi_ss_b = 1'b1;
		spi_mosi = 1'b0;
		rst_b = 1'b0;
		oe_mid = 1'b1;
		mismatches = 0;
		total_checks = 0;
		seed_val = $urandom(3);
		reset_mirror();
		cyc(2);
		rst_b = 1'b1;
		cyc(2);
		note_out(exp_out());
		tick_cnt(10, 16'h000a);
		for (k = 9'h0bf; k <= 9'h0cd; k++) rd_chk(9'(k));
		rd_chk(9'h1ff);
		// skip enable on for the upper half, merge enable on for the lower half, all axis codes
		for (k = 0; k < 8; k++) wr(9'h0c0, {2'h0, 2'(k + 1), 2'(k), 1'b0, ~k[2], k[2], 7'h00});
		rd_chk(9'h0c0);
		repeat (3) begin
			wr(9'h0c3, 16'($urandom));
			wr(9'h0c4, 16'($urandom));
			rd_chk(9'h0c3);
			rd_chk(9'h0c4);
		end
		wr(9'h0c5, 16'hffff);
		rd_chk(9'h0c5);
		wr(9'h0c5, 16'h0001);
		rd_chk(9'h0c5);
		wr(9'h0c8, 16'($urandom));
		wr(9'h0c9, 16'($urandom));
		wr(9'h0c2, 16'h00e0);
		rd_chk(9'h0c8);
		wr(9'h0c2, 16'h00e4);
		rd_chk(9'h0c2);
		rd_chk(9'h0c9);
		wr(9'h0c7, 16'h0005);
		tick_cnt(50, 16'h000a);
		wr(9'h0c6, 16'habcd);
		wr(9'h1ff, 16'h5a5a);
		wr(9'h0cc, 16'($urandom));
		rd_chk(9'h0c6);
		rd_chk(9'h0cc);
		// aborted frame must leave the register untouched
		spi_xfer(9'h0c3, 1'b1, 16'h1234, 20, rd);
		rd_chk(9'h0c3);
		rst_b = 1'b0;
		cyc(2);
		reset_mirror();
		note_out(exp_out());
		rst_b = 1'b1;
		cyc(2);
		rd_chk(9'h0c5);
		cyc(3);
		print_verdict();
	end
endmodule
